/* File: rtl/usc_top.sv */
// Serial status and control block: register, transmit queue, receive flags
// Assumes a receive engine outside that reports characters and errors
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module usc_top #(
  parameter int DEPTH = usc_pkg::FIFO_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output      logic [15:0] reg_rdata,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_parity_error,
  input  wire logic        rx_framing_error,
  input  wire logic        rx_line_idle,
  output      logic        serial_transmit_pin_out,
  output      logic        serial_transmit_pin_oe,
  output      logic        irq
);
  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic [1:0]  tx_interrupt_mode_reg;
  logic        tx_idle_polarity_invert_reg;
  logic        tx_break_request_reg;
  logic        tx_enable_reg;
  logic [1:0]  rx_interrupt_mode_reg;
  logic        address_detect_enable_reg;
  logic        infrared_encoder_enable_reg;
  logic        overrun_error_flag_reg;
  logic        parity_error_flag_reg;
  logic        framing_error_flag_reg;
  logic [15:0] baud_div_reg;
  logic [15:0] baud_cnt_reg;
  logic [usc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [usc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [15:0] rdata_reg;
  logic        brk_pending_reg;
  logic [7:0]  txq_mem [DEPTH];
  logic [7:0]  rxq_mem [DEPTH];
  logic [$clog2(DEPTH):0] txq_cnt_reg;
  logic [$clog2(DEPTH):0] rxq_cnt_reg;
  logic [$clog2(DEPTH)-1:0] txq_rd_reg;
  logic [$clog2(DEPTH)-1:0] txq_wr_reg;
  logic [$clog2(DEPTH)-1:0] rxq_rd_reg;
  logic [$clog2(DEPTH)-1:0] rxq_wr_reg;
  logic        bit_tick;
  logic        wr_status;
  logic        wr_txdata;
  logic        rd_rxdata;
  logic        txq_push;
  logic        txq_pop;
  logic        rxq_push;
  logic        rxq_pop;
  logic        tx_full;
  logic        tx_shift_empty;
  logic        tx_event;
  logic        rx_event;
  logic [15:0] status_word;
  usc_pkg::usc_tx_cmd_s  tx_cmd;
  usc_pkg::usc_tx_stat_s tx_stat;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  assign wr_status = reg_write && hit(reg_addr, usc_pkg::ADDR_STATUS_CONTROL);
  assign wr_txdata = reg_write && hit(reg_addr, usc_pkg::ADDR_TX_DATA);
  assign rd_rxdata = reg_read && hit(reg_addr, usc_pkg::ADDR_RX_DATA);

  // ----------------------------------------------------------------
  // Bit-rate divider
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n || baud_cnt_reg == 16'h0000) begin
      baud_cnt_reg <= baud_div_reg;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 16'h0001;
    end
  end
  assign bit_tick = reset_n && (baud_cnt_reg == 16'h0000);

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  assign tx_full  = (txq_cnt_reg == ($clog2(DEPTH)+1)'(DEPTH));
  assign txq_push = wr_txdata && !tx_full && tx_enable_reg;
  assign txq_pop  = tx_stat.taken;
  // Break occupies the engine without consuming a character
  assign tx_cmd.load = tx_enable_reg && (brk_pending_reg || txq_cnt_reg != '0);
  assign tx_cmd.brk  = brk_pending_reg;
  assign tx_cmd.data = txq_mem[txq_rd_reg];

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !tx_enable_reg) begin
      txq_cnt_reg <= '0;
      txq_rd_reg  <= '0;
      txq_wr_reg  <= '0;
    end else begin
      if (txq_push) begin
        txq_wr_reg <= txq_wr_reg + 1'b1;
      end
      if (txq_pop && !brk_pending_reg) begin
        txq_rd_reg <= txq_rd_reg + 1'b1;
      end
      txq_cnt_reg <= txq_cnt_reg + ($clog2(DEPTH)+1)'(txq_push)
                     - ($clog2(DEPTH)+1)'(txq_pop && !brk_pending_reg);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (txq_push) begin
      txq_mem[txq_wr_reg] <= reg_wdata[7:0];
    end
  end

  usc_tx_engine u_tx (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .abort    (!tx_enable_reg),
    .bit_tick (bit_tick),
    .cmd      (tx_cmd),
    .stat     (tx_stat)
  );

  assign tx_shift_empty = !tx_stat.busy && (txq_cnt_reg == '0);

  // ----------------------------------------------------------------
  // Break request: held until its frame completes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !tx_enable_reg) begin
      tx_break_request_reg <= 1'b0;
      brk_pending_reg      <= 1'b0;
    end else begin
      if (txq_pop && brk_pending_reg) begin
        brk_pending_reg <= 1'b0;
      end else if (wr_status && reg_wdata[usc_pkg::BIT_TXBRK] && !tx_break_request_reg) begin
        brk_pending_reg <= 1'b1;
      end
      if (wr_status && reg_wdata[usc_pkg::BIT_TXBRK]) begin
        tx_break_request_reg <= 1'b1;
      end else if (tx_stat.done && !brk_pending_reg) begin
        tx_break_request_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_interrupt_mode_reg       <= 2'h0;
      tx_idle_polarity_invert_reg <= 1'b0;
      tx_enable_reg               <= 1'b0;
      rx_interrupt_mode_reg       <= 2'h0;
      address_detect_enable_reg   <= 1'b0;
      infrared_encoder_enable_reg <= 1'b0;
      baud_div_reg                <= usc_pkg::BAUD_DIV_RST;
      irq_mask_reg                <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        usc_pkg::ADDR_STATUS_CONTROL: begin
          tx_interrupt_mode_reg <= {reg_wdata[usc_pkg::BIT_TXIM1],
                                    reg_wdata[usc_pkg::BIT_TXIM0]};
          tx_idle_polarity_invert_reg <= reg_wdata[usc_pkg::BIT_TXINV];
          tx_enable_reg             <= reg_wdata[usc_pkg::BIT_TXEN];
          rx_interrupt_mode_reg     <= reg_wdata[usc_pkg::BIT_RXIM1:usc_pkg::BIT_RXIM0];
          address_detect_enable_reg <= reg_wdata[usc_pkg::BIT_ADDREN];
        end
        usc_pkg::ADDR_IRQ_MASK:   irq_mask_reg <= reg_wdata[usc_pkg::IRQ_W-1:0];
        usc_pkg::ADDR_BAUD_DIV:   baud_div_reg <= reg_wdata;
        usc_pkg::ADDR_MISC_CTRL:  infrared_encoder_enable_reg <= reg_wdata[usc_pkg::BIT_INFRARED_ENCODER_ENABLE];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit pin: idle level depends on encoder mode
  // ----------------------------------------------------------------
  always_comb begin
    // Without encoder invert flips the whole line; with it invert only sets the idle level, data passes unflipped
    if (infrared_encoder_enable_reg) begin
      serial_transmit_pin_out = tx_stat.busy ? tx_stat.line
                                             : tx_idle_polarity_invert_reg;
    end else begin
      serial_transmit_pin_out = tx_stat.line ^ tx_idle_polarity_invert_reg;
    end
  end
  assign serial_transmit_pin_oe = tx_enable_reg;

  // ----------------------------------------------------------------
  // Receive queue and flags
  // ----------------------------------------------------------------
  assign rxq_pop  = rd_rxdata && (rxq_cnt_reg != '0);
  assign rxq_push = rx_char_valid && (rxq_cnt_reg != ($clog2(DEPTH)+1)'(DEPTH) || rxq_pop);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rxq_cnt_reg <= '0;
      rxq_rd_reg  <= '0;
      rxq_wr_reg  <= '0;
    end else begin
      if (rxq_push) begin
        rxq_wr_reg <= rxq_wr_reg + 1'b1;
      end
      if (rxq_pop) begin
        rxq_rd_reg <= rxq_rd_reg + 1'b1;
      end
      rxq_cnt_reg <= rxq_cnt_reg + ($clog2(DEPTH)+1)'(rxq_push)
                     - ($clog2(DEPTH)+1)'(rxq_pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rxq_push) begin
      rxq_mem[rxq_wr_reg] <= rx_char;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      overrun_error_flag_reg <= 1'b0;
      parity_error_flag_reg  <= 1'b0;
      framing_error_flag_reg <= 1'b0;
    end else begin
      // Set beats a simultaneous software clear
      if (rx_char_valid && !rxq_push) begin
        overrun_error_flag_reg <= 1'b1;
      end else if (wr_status && !reg_wdata[usc_pkg::BIT_OVERRUN_ERROR_FLAG]) begin
        overrun_error_flag_reg <= 1'b0;
      end
      if (rxq_push) begin
        parity_error_flag_reg  <= rx_parity_error;
        framing_error_flag_reg <= rx_framing_error;
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    case (tx_interrupt_mode_reg)
      usc_pkg::TXIM_TO_SHIFT: tx_event = txq_pop && !brk_pending_reg;
      usc_pkg::TXIM_DONE:     tx_event = tx_stat.done && txq_cnt_reg == '0;
      usc_pkg::TXIM_EMPTY:    tx_event = txq_pop && !brk_pending_reg
                                         && txq_cnt_reg == ($clog2(DEPTH)+1)'(1) && !txq_push;
      default:                tx_event = 1'b0;
    endcase
  end

  always_comb begin
    case (rx_interrupt_mode_reg)
      usc_pkg::RXIM_FULL: rx_event = rxq_push && !rxq_pop
                                     && rxq_cnt_reg == ($clog2(DEPTH)+1)'(DEPTH-1);
      usc_pkg::RXIM_3Q:   rx_event = rxq_push && !rxq_pop
                                     && rxq_cnt_reg == ($clog2(DEPTH)+1)'(DEPTH-2);
      default:            rx_event = rxq_push;
    endcase
  end

  wire rd_irq = reg_read && hit(reg_addr, usc_pkg::ADDR_IRQ_STATUS);
  wire [usc_pkg::IRQ_W-1:0] ev = {rx_char_valid && !rxq_push, rx_event, tx_event};

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
    end else begin
      // Read clears, new events in that cycle survive
      irq_status_reg <= (rd_irq ? '0 : irq_status_reg) | ev;
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[usc_pkg::BIT_TXIM1]  = tx_interrupt_mode_reg[1];
    status_word[usc_pkg::BIT_TXINV]  = tx_idle_polarity_invert_reg;
    status_word[usc_pkg::BIT_TXIM0]  = tx_interrupt_mode_reg[0];
    status_word[usc_pkg::BIT_TXBRK]  = tx_break_request_reg;
    status_word[usc_pkg::BIT_TXEN]   = tx_enable_reg;
    status_word[usc_pkg::BIT_TXBF]   = tx_full;
    status_word[usc_pkg::BIT_TXSE]   = tx_shift_empty;
    status_word[usc_pkg::BIT_RXIM1]  = rx_interrupt_mode_reg[1];
    status_word[usc_pkg::BIT_RXIM0]  = rx_interrupt_mode_reg[0];
    status_word[usc_pkg::BIT_ADDREN] = address_detect_enable_reg;
    status_word[usc_pkg::BIT_RXIDLE] = rx_line_idle;
    status_word[usc_pkg::BIT_PARITY_ERROR_FLAG]   = parity_error_flag_reg;
    status_word[usc_pkg::BIT_FRAMING_ERROR_FLAG]   = framing_error_flag_reg;
    status_word[usc_pkg::BIT_OVERRUN_ERROR_FLAG]   = overrun_error_flag_reg;
    status_word[usc_pkg::BIT_RXDA]   = (rxq_cnt_reg != '0);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !reg_read) begin
      rdata_reg <= 16'h0000;
    end else begin
      case (reg_addr)
        usc_pkg::ADDR_STATUS_CONTROL: rdata_reg <= status_word;
        usc_pkg::ADDR_RX_DATA:    rdata_reg <= {8'h00, rxq_mem[rxq_rd_reg]};
        usc_pkg::ADDR_IRQ_STATUS: rdata_reg <= {13'h0000, irq_status_reg};
        usc_pkg::ADDR_IRQ_MASK:   rdata_reg <= {13'h0000, irq_mask_reg};
        usc_pkg::ADDR_BAUD_DIV:   rdata_reg <= baud_div_reg;
        usc_pkg::ADDR_MISC_CTRL:  rdata_reg <= {15'h0000, infrared_encoder_enable_reg};
        default:                  rdata_reg <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_full_flag;
    @(posedge ref_clk) disable iff (!reset_n)
      txq_push && !(txq_pop && !brk_pending_reg)
        && txq_cnt_reg == ($clog2(DEPTH)+1)'(DEPTH-1)
        |=> tx_full && status_word[usc_pkg::BIT_TXBF];
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

  property p_shift_empty;
    @(posedge ref_clk) disable iff (!reset_n)
      txq_push |=> !tx_shift_empty;
  endproperty
  a_shift_empty: assert property (p_shift_empty) else $error("shift empty wrong");

  property p_disable_flush;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(tx_enable_reg) |-> !serial_transmit_pin_oe ##1 (txq_cnt_reg == '0 && !tx_stat.busy);
  endproperty
  a_disable_flush: assert property (p_disable_flush) else $error("abort failed");

  property p_idle_level;
    @(posedge ref_clk) disable iff (!reset_n)
      !tx_stat.busy && tx_enable_reg && !infrared_encoder_enable_reg
        |-> serial_transmit_pin_out == !tx_idle_polarity_invert_reg;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_break_start;
    @(posedge ref_clk) disable iff (!reset_n)
      txq_pop && brk_pending_reg |=> tx_break_request_reg;
  endproperty
  a_break_start: assert property (p_break_start) else $error("break dropped");

  property p_tx_mode;
    @(posedge ref_clk) disable iff (!reset_n)
      tx_interrupt_mode_reg == 2'h3 && !irq_status_reg[usc_pkg::IRQ_TX]
        |=> !irq_status_reg[usc_pkg::IRQ_TX];
  endproperty
  a_tx_mode: assert property (p_tx_mode) else $error("reserved mode fired");

  property p_rx_mode;
    @(posedge ref_clk) disable iff (!reset_n)
      rx_event && rx_interrupt_mode_reg == usc_pkg::RXIM_FULL
        |=> rxq_cnt_reg == ($clog2(DEPTH)+1)'(DEPTH);
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("rx event early");

  property p_overrun;
    @(posedge ref_clk) disable iff (!reset_n)
      rx_char_valid && !rxq_push |=> overrun_error_flag_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost");
endmodule

/* File: rtl/usc_pkg.sv */
// Constants and carriers for the serial status and control block
// Shared by the block and its transmit engine
package usc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TX_DATA        = 4'h1;
  localparam logic [3:0] ADDR_RX_DATA        = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK       = 4'h4;
  localparam logic [3:0] ADDR_BAUD_DIV       = 4'h5;
  localparam logic [3:0] ADDR_MISC_CTRL      = 4'h6;
  // ----------------------------------------------------------------
  // Status and control field positions
  // ----------------------------------------------------------------
  localparam int BIT_TXIM1    = 15;
  localparam int BIT_TXINV    = 14;
  localparam int BIT_TXIM0    = 13;
  localparam int BIT_TXBRK    = 11;
  localparam int BIT_TXEN     = 10;
  localparam int BIT_TXBF     = 9;
  localparam int BIT_TXSE     = 8;
  localparam int BIT_RXIM1    = 7;
  localparam int BIT_RXIM0    = 6;
  localparam int BIT_ADDREN   = 5;
  localparam int BIT_RXIDLE   = 4;
  localparam int BIT_PARITY_ERROR_FLAG     = 3;
  localparam int BIT_FRAMING_ERROR_FLAG     = 2;
  localparam int BIT_OVERRUN_ERROR_FLAG     = 1;
  localparam int BIT_RXDA     = 0;
  // Interrupt status bits
  localparam int IRQ_TX       = 0;
  localparam int IRQ_RX       = 1;
  localparam int IRQ_OVERRUN_ERROR_FLAG     = 2;
  localparam int IRQ_W        = 3;
  // Misc control bits
  localparam int BIT_INFRARED_ENCODER_ENABLE     = 0;
  // ----------------------------------------------------------------
  // Encodings, sizes, reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] TXIM_TO_SHIFT = 2'h0;
  localparam logic [1:0] TXIM_DONE     = 2'h1;
  localparam logic [1:0] TXIM_EMPTY    = 2'h2;
  localparam logic [1:0] RXIM_FULL     = 2'h3;
  localparam logic [1:0] RXIM_3Q       = 2'h2;
  localparam int         FIFO_DEPTH    = 4;
  localparam int         BREAK_ZEROS   = 12;
  localparam int         DATA_BITS     = 8;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0003;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       load;
    logic       brk;
    logic [7:0] data;
  } usc_tx_cmd_s;
  typedef struct packed {
    logic busy;
    logic taken;
    logic done;
    logic line;
  } usc_tx_stat_s;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_BITS  = 4'h4,
    TX_STOP  = 4'h8
  } usc_tx_state_e;
endpackage

/* File: rtl/usc_tx_engine.sv */
// Transmit shift engine: start, data or break zeros, stop
// Assumes a one-cycle bit-rate enable and a loaded character
`timescale 1ns/1ps
module usc_tx_engine (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  abort,
  input  wire logic                  bit_tick,
  input  wire usc_pkg::usc_tx_cmd_s  cmd,
  output      usc_pkg::usc_tx_stat_s stat
);
  usc_pkg::usc_tx_state_e state_reg;
  logic [11:0]            shift_reg;
  logic [3:0]             count_reg;
  logic                   line_reg;
  logic                   done_reg;

  assign stat.busy  = (state_reg != usc_pkg::TX_IDLE);
  assign stat.taken = cmd.load && (state_reg == usc_pkg::TX_IDLE);
  assign stat.done  = done_reg;
  assign stat.line  = line_reg;

  always_ff @(posedge ref_clk) begin
    done_reg <= 1'b0;
    if (!reset_n || abort) begin
      state_reg <= usc_pkg::TX_IDLE;
      shift_reg <= 12'h000;
      count_reg <= 4'h0;
      line_reg  <= 1'b1;
    end else begin
      case (state_reg)
        usc_pkg::TX_IDLE: begin
          line_reg <= 1'b1;
          if (cmd.load) begin
            // Break sends twelve zeros in place of data
            shift_reg <= cmd.brk ? 12'h000 : {4'h0, cmd.data};
            count_reg <= cmd.brk ? 4'(usc_pkg::BREAK_ZEROS - 1)
                                 : 4'(usc_pkg::DATA_BITS - 1);
            state_reg <= usc_pkg::TX_START;
          end
        end
        usc_pkg::TX_START: begin
          if (bit_tick) begin
            line_reg  <= 1'b0;
            state_reg <= usc_pkg::TX_BITS;
          end
        end
        usc_pkg::TX_BITS: begin
          if (bit_tick) begin
            line_reg  <= shift_reg[0];
            shift_reg <= {1'b0, shift_reg[11:1]};
            count_reg <= count_reg - 4'h1;
            if (count_reg == 4'h0) begin
              state_reg <= usc_pkg::TX_STOP;
            end
          end
        end
        usc_pkg::TX_STOP: begin
          if (bit_tick) begin
            // First tick drives the stop bit, second ends it, whatever the last data bit
            line_reg  <= 1'b1;
            count_reg <= 4'h0;
            if (count_reg == 4'h0) begin
              state_reg <= usc_pkg::TX_IDLE;
              done_reg  <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= usc_pkg::TX_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: sim/usc_remote_rx.sv */
// Remote receiver model watching the transmit line
// Assumes a bit time of BIT cycles and a pulled-up line
`timescale 1ns/1ps
module usc_remote_rx #(
  parameter int BIT = 4
) (
  input  wire logic       ref_clk,
  input  wire logic       line,
  output      logic [7:0] data,
  output      logic [4:0] stop_idx,
  output      int         frames
);
  int k;
  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  // Stop index tells a break from a character
  initial begin
    frames = 0;
    data = 8'h00;
    stop_idx = 5'h00;
    forever begin
      @(posedge ref_clk);
      if (line === 1'b0) begin
        repeat (BIT / 2) @(posedge ref_clk);
        for (k = 0; k < 16; k++) begin
          repeat (BIT) @(posedge ref_clk);
          if (k < 8) data[k] = line;
          if (k >= 8 && line === 1'b1) break;
        end
        stop_idx = 5'(k);
        frames++;
      end
    end
  end
endmodule

/* File: sim/uart_status_control_test.sv */
// Bench for the serial status and control block
// Assumes the remote receiver model and a pulled-up transmit line
`timescale 1ns/1ps
module uart_status_control_test;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic        rx_char_valid = 1'b0;
  logic [7:0]  rx_char = 8'h00;
  logic        rx_err = 1'b0;
  logic        pin_out;
  logic        pin_oe;
  logic        irq;
  logic        line;
  logic [7:0]  r_data;
  logic [4:0]  r_stop;
  logic [15:0] v;
  int          frames;
  int          fails = 0;
  int          tests_run = 0;
  int          i;
  int          f0;
  // Rows: infrared_encoder_enable, inv, idle level / txim, at start, after / rxim, count
  logic [2:0]  idle_rows [4] = '{3'b001, 3'b010, 3'b100, 3'b111};
  logic [3:0]  txim_rows [4] = '{4'h2, 4'h5, 4'hA, 4'hC};
  logic [3:0]  rxim_rows [3] = '{4'hF, 4'hA, 4'h0};
  always #5 ref_clk = ~ref_clk;
  // Released line floats high
  assign line = pin_oe ? pin_out : 1'b1;
  usc_top u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_error(rx_err), .rx_framing_error(rx_err), .rx_line_idle(1'b1),
    .serial_transmit_pin_out(pin_out), .serial_transmit_pin_oe(pin_oe), .irq(irq)
  );
  usc_remote_rx u_far (
    .ref_clk(ref_clk), .line(line), .data(r_data), .stop_idx(r_stop), .frames(frames)
  );
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded wait; a hang ends the run
  task automatic wait_frames(input int n);
    int j;
    for (j = 0; j < 3000 && frames < n; j++) @(posedge ref_clk);
    if (frames < n) begin
      fails++;
      conclude();
    end
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic push_rx(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      rx_char_valid <= 1'b1;
      rx_char <= rx_char + 8'h01;
      @(posedge ref_clk);
      rx_char_valid <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("status reset", 16'h0110, v);
    chk("oe reset", 16'h0000, {15'h0000, pin_oe});
    rd(4'hF, v);
    chk("unmapped", 16'h0000, v);
    wr(usc_pkg::ADDR_IRQ_MASK, 16'h0007);
    foreach (txim_rows[r]) begin
      wr(usc_pkg::ADDR_STATUS_CONTROL, {txim_rows[r][3], 1'b0, txim_rows[r][2], 13'h0400});
      rd(usc_pkg::ADDR_IRQ_STATUS, v);
      f0 = frames;
      wr(usc_pkg::ADDR_TX_DATA, 16'h00A5);
      rd(usc_pkg::ADDR_STATUS_CONTROL, v);
      chk("shift busy", 16'h0000, v & 16'h0100);
      chk("oe on", 16'h0001, {15'h0000, pin_oe});
      repeat (12) @(posedge ref_clk);
      chk("irq start", {15'h0000, txim_rows[r][1]}, {15'h0000, irq});
      rd(usc_pkg::ADDR_IRQ_STATUS, v);
      chk("tx ev start", {15'h0000, txim_rows[r][1]}, v & 16'h0001);
      wait_frames(f0 + 1);
      chk("frame data", 16'h00A5, {8'h00, r_data});
      chk("frame stop", 16'h0008, {11'h000, r_stop});
      rd(usc_pkg::ADDR_IRQ_STATUS, v);
      chk("tx ev after", {15'h0000, txim_rows[r][0]}, v & 16'h0001);
      rd(usc_pkg::ADDR_STATUS_CONTROL, v);
      chk("shift idle", 16'h0100, v & 16'h0100);
    end
    f0 = frames;
    wr(usc_pkg::ADDR_STATUS_CONTROL, 16'h0C00);
    wait_frames(f0 + 1);
    chk("break stop", 16'h000C, {11'h000, r_stop});
    chk("break data", 16'h0000, {8'h00, r_data});
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("break clr", 16'h0000, v & 16'h0800);
    f0 = frames;
    for (i = 0; i < 6; i++) wr(usc_pkg::ADDR_TX_DATA, 16'h0030 + 16'(i));
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("full", 16'h0200, v & 16'h0200);
    wait_frames(f0 + 1);
    chk("first data", 16'h0030, {8'h00, r_data});
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("not full", 16'h0000, v & 16'h0300);
    // Abort in mid-frame
    wr(usc_pkg::ADDR_STATUS_CONTROL, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk("oe off", 16'h0000, {15'h0000, pin_oe});
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("flushed", 16'h0100, v & 16'h0300);
    repeat (80) @(posedge ref_clk);
    f0 = frames;
    repeat (200) @(posedge ref_clk);
    chk("no frames", 16'(f0), 16'(frames));
    foreach (rxim_rows[r]) begin
      for (i = 0; i < 4; i++) rd(usc_pkg::ADDR_RX_DATA, v);
      wr(usc_pkg::ADDR_STATUS_CONTROL, {8'h04, rxim_rows[r][3:2], 6'h00});
      rd(usc_pkg::ADDR_IRQ_STATUS, v);
      push_rx(int'(rxim_rows[r][1:0]));
      chk("rx irq early", 16'h0000, {15'h0000, irq});
      push_rx(1);
      chk("rx irq", 16'h0001, {15'h0000, irq});
    end
    rx_err <= 1'b1;
    push_rx(4);
    rx_err <= 1'b0;
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("overrun", 16'h000F, v & 16'h000F);
    wr(usc_pkg::ADDR_STATUS_CONTROL, 16'h0400);
    rd(usc_pkg::ADDR_STATUS_CONTROL, v);
    chk("overrun clr", 16'h0000, v & 16'h0002);
    foreach (idle_rows[r]) begin
      wr(usc_pkg::ADDR_MISC_CTRL, {15'h0000, idle_rows[r][2]});
      wr(usc_pkg::ADDR_STATUS_CONTROL, {1'b0, idle_rows[r][1], 14'h0400});
      @(posedge ref_clk);
      #1;
      chk("idle", {15'h0000, idle_rows[r][0]}, {15'h0000, pin_out});
    end
    conclude();
  end
endmodule
